// ==== common/rtc_map.svh ====
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
`define RTC_A_SEC   4'h0
`define RTC_A_MIN   4'h1
`define RTC_A_HOUR  4'h2
`define RTC_A_WEEK  4'h3
`define RTC_A_DATE  4'h4
`define RTC_A_MONTH 4'h5
`define RTC_A_YEAR  4'h6
`define RTC_A_RAM   4'h7
`define RTC_A_AMIN  4'h8
`define RTC_A_AHOUR 4'h9
`define RTC_A_ADAY  4'hA
`define RTC_A_TLO   4'hB
`define RTC_A_THI   4'hC
`define RTC_A_EXT   4'hD
`define RTC_A_FLAG  4'hE
`define RTC_A_CTRL  4'hF
`define RTC_M_SEC   8'h7F
`define RTC_M_HOUR  8'h3F
`define RTC_M_MONTH 8'h1F
`define RTC_M_EXT   8'h5F
`define RTC_B_TARGET 6
`define RTC_B_RUN   4
`define RTC_B_TMR   4
`define RTC_B_ALM   3
`define RTC_B_LOST  1
`define RTC_B_STOP  1
`define RTC_B_MASK  7
`define RTC_BCD_01  8'h01
`define RTC_BCD_12  8'h12
`define RTC_BCD_23  8'h23
`define RTC_BCD_28  8'h28
`define RTC_BCD_29  8'h29
`define RTC_BCD_30  8'h30
`define RTC_BCD_31  8'h31
`define RTC_BCD_59  8'h59
`define RTC_BCD_99  8'h99
`define RTC_CLK_HZ  32'h02FA_F080
`define RTC_CLK_NS  32'h0000_0014
`define RTC_PRE_HZ  32'h0001_0000
// 122 us and 7813 us, in ns
`define RTC_TRTN_FAST_NS 32'h0001_DC90
`define RTC_TRTN_SLOW_NS 32'h0077_3788
`endif

// ==== common/rtc_pkg.sv ====
package rtc_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rtc_req_t;
  typedef enum logic [1:0] {
    RTC_SRC_4096 = 2'b00,
    RTC_SRC_64   = 2'b01,
    RTC_SRC_1HZ  = 2'b10,
    RTC_SRC_MIN  = 2'b11
  } rtc_tsrc_t;
endpackage

// ==== src/rtc_core.sv ====
`timescale 1ns/100ps
`include "rtc_map.svh"
module rtc_core
  import rtc_pkg::*;
#(
  parameter int unsigned CLK_HZ    = `RTC_CLK_HZ,
  parameter int unsigned TRTN_FAST = `RTC_TRTN_FAST_NS / `RTC_CLK_NS,
  parameter int unsigned TRTN_SLOW = `RTC_TRTN_SLOW_NS / `RTC_CLK_NS
) (
  input  wire logic       CLK_SYS,
  input  wire logic       NRST,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [3:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  input  wire logic       CLOCK_OUT_ENABLE_PIN,
  output logic            CLOCK_OUT_PIN,
  output logic            CLOCK_OUT_OE,
  output logic            IRQ_N_OUT,
  output logic            IRQ_N_OE
);

  generate
    if (CLK_HZ < `RTC_PRE_HZ || TRTN_FAST < 1 || TRTN_SLOW < 1 || TRTN_SLOW >= 2 ** 20) begin : g_bad
      $error("rtc_core parameters out of range");
    end
  endgenerate

  rtc_req_t    req;
  logic [15:0] wsel;
  logic [31:0] phase;
  logic [31:0] next_phase;
  logic        tick;
  logic [15:0] pre;
  logic        run_tick;
  logic        sec_tick;
  logic        t4096;
  logic        t64;
  logic [7:0]  sec;
  logic [7:0]  mins;
  logic [7:0]  hour;
  logic [6:0]  wday;
  logic [7:0]  date;
  logic [7:0]  month;
  logic [7:0]  year;
  logic [7:0]  last_day;
  logic        leap;
  logic        sec_wrap;
  logic        min_wrap;
  logic        hour_wrap;
  logic        day_wrap;
  logic        mon_wrap;
  logic [7:0]  ram;
  logic [7:0]  al_min;
  logic [7:0]  al_hour;
  logic [7:0]  al_day;
  logic [7:0]  tp_lo;
  logic [7:0]  tp_hi;
  logic [7:0]  ext;
  logic        tmr_irq_en;
  logic        alm_irq_en;
  logic        stop;
  logic        tmr_flag;
  logic        alm_flag;
  logic        lost_flag;
  logic [11:0] preset;
  logic [11:0] tcount;
  logic        run_q;
  logic        timer_run;
  logic        src_tick;
  logic        tmr_load;
  logic        tmr_event;
  logic        al_check;
  logic        match_min;
  logic        match_hour;
  logic        match_day;
  logic        alarm_event;
  logic [19:0] rtn;
  logic        irq_req;
  logic [2:0]  oe_sync;
  logic        oe_filt;
  logic        sel_bit;
  logic [7:0]  rd_mux;

  assign req = {REG_WR, REG_RD, REG_ADDR, REG_WDATA};
  assign wsel = req.wr ? (16'h0001 << req.addr) : 16'h0000;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // 65536 Hz enable from the system clock
  always_comb begin
    next_phase = phase + `RTC_PRE_HZ;
    tick = 1'b0;
    if (next_phase >= CLK_HZ) begin
      next_phase = next_phase - CLK_HZ;
      tick = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      phase <= 32'h0000_0000;
    end else begin
      phase <= next_phase;
    end
  end

  // Sub-second prescaler
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      pre <= 16'h0000;
    end else if (wsel[`RTC_A_SEC]) begin
      pre <= 16'h0000;
    end else if (run_tick) begin
      pre <= pre + 16'h0001;
    end
  end

  assign run_tick = tick && !stop;
  assign sec_tick = run_tick && (&pre) && !wsel[`RTC_A_SEC];
  assign t4096 = run_tick && (&pre[3:0]);
  assign t64 = run_tick && (&pre[9:0]);

  // Carry chain
  assign sec_wrap = sec_tick && sec == `RTC_BCD_59;
  assign min_wrap = sec_wrap && mins == `RTC_BCD_59;
  assign hour_wrap = min_wrap && hour == `RTC_BCD_23;
  assign day_wrap = hour_wrap && date == last_day;
  assign mon_wrap = day_wrap && month == `RTC_BCD_12;
  assign leap = year[1:0] == {year[4], 1'b0};

  always_comb begin
    case (month)
      8'h02: last_day = leap ? `RTC_BCD_29 : `RTC_BCD_28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = `RTC_BCD_30;
      default: last_day = `RTC_BCD_31;
    endcase
  end

  // Time of day, packed BCD
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      sec <= 8'h00;
      mins <= 8'h00;
      hour <= 8'h00;
    end else begin
      if (wsel[`RTC_A_SEC]) begin
        sec <= req.wdata & `RTC_M_SEC;
      end else if (sec_wrap) begin
        sec <= 8'h00;
      end else if (sec_tick) begin
        sec <= bcd_inc(sec);
      end
      if (wsel[`RTC_A_MIN]) begin
        mins <= req.wdata & `RTC_M_SEC;
      end else if (min_wrap) begin
        mins <= 8'h00;
      end else if (sec_wrap) begin
        mins <= bcd_inc(mins);
      end
      if (wsel[`RTC_A_HOUR]) begin
        hour <= req.wdata & `RTC_M_HOUR;
      end else if (hour_wrap) begin
        hour <= 8'h00;
      end else if (min_wrap) begin
        hour <= bcd_inc(hour);
      end
    end
  end

  // Calendar
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      wday <= 7'h01;
      date <= `RTC_BCD_01;
      month <= `RTC_BCD_01;
      year <= 8'h00;
    end else begin
      if (wsel[`RTC_A_WEEK]) begin
        wday <= req.wdata[6:0];
      end else if (hour_wrap) begin
        wday <= {wday[5:0], wday[6]};
      end
      if (wsel[`RTC_A_DATE]) begin
        date <= req.wdata & `RTC_M_HOUR;
      end else if (day_wrap) begin
        date <= `RTC_BCD_01;
      end else if (hour_wrap) begin
        date <= bcd_inc(date);
      end
      if (wsel[`RTC_A_MONTH]) begin
        month <= req.wdata & `RTC_M_MONTH;
      end else if (mon_wrap) begin
        month <= `RTC_BCD_01;
      end else if (day_wrap) begin
        month <= bcd_inc(month);
      end
      if (wsel[`RTC_A_YEAR]) begin
        year <= req.wdata;
      end else if (mon_wrap) begin
        year <= (year == `RTC_BCD_99) ? 8'h00 : bcd_inc(year);
      end
    end
  end

  // Plain storage registers
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ram <= 8'h00;
      al_min <= 8'h00;
      al_hour <= 8'h00;
      al_day <= 8'h00;
      tp_lo <= 8'h00;
      tp_hi <= 8'h00;
      ext <= 8'h00;
      tmr_irq_en <= 1'b0;
      alm_irq_en <= 1'b0;
      stop <= 1'b0;
    end else begin
      if (wsel[`RTC_A_RAM]) ram <= req.wdata;
      if (wsel[`RTC_A_AMIN]) al_min <= req.wdata;
      if (wsel[`RTC_A_AHOUR]) al_hour <= req.wdata;
      if (wsel[`RTC_A_ADAY]) al_day <= req.wdata;
      if (wsel[`RTC_A_TLO]) tp_lo <= req.wdata;
      if (wsel[`RTC_A_THI]) tp_hi <= req.wdata;
      if (wsel[`RTC_A_EXT]) ext <= req.wdata & `RTC_M_EXT;
      if (wsel[`RTC_A_CTRL]) begin
        tmr_irq_en <= req.wdata[`RTC_B_TMR];
        alm_irq_en <= req.wdata[`RTC_B_ALM];
        stop <= req.wdata[`RTC_B_STOP];
      end
    end
  end

  // Fixed-cycle timer
  assign preset = {tp_hi[3:0], tp_lo};
  assign timer_run = ext[`RTC_B_RUN];
  assign tmr_load = timer_run && !run_q;

  always_comb begin
    unique case (rtc_tsrc_t'(ext[1:0]))
      RTC_SRC_4096: src_tick = t4096;
      RTC_SRC_64:   src_tick = t64;
      RTC_SRC_1HZ:  src_tick = sec_tick;
      RTC_SRC_MIN:  src_tick = sec_wrap;
    endcase
  end

  assign tmr_event = timer_run && !tmr_load && src_tick && tcount == 12'h001;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      run_q <= 1'b0;
      tcount <= 12'h000;
    end else begin
      run_q <= timer_run;
      if (tmr_load) begin
        tcount <= preset;
      end else if (timer_run && src_tick) begin
        if (tcount <= 12'h001) begin
          tcount <= preset;
        end else begin
          tcount <= tcount - 12'h001;
        end
      end
    end
  end

  // Alarm compare, one cycle after each minute change
  assign match_min = al_min[`RTC_B_MASK] || al_min[6:0] == mins[6:0];
  assign match_hour = al_hour[`RTC_B_MASK] || al_hour[5:0] == hour[5:0];
  always_comb begin
    if (al_day[`RTC_B_MASK]) begin
      match_day = 1'b1;
    end else if (ext[`RTC_B_TARGET]) begin
      match_day = al_day[5:0] == date[5:0];
    end else begin
      match_day = |(al_day[6:0] & wday);
    end
  end
  assign alarm_event = al_check && match_min && match_hour && match_day;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      al_check <= 1'b0;
    end else begin
      al_check <= sec_wrap;
    end
  end

  // Event flags; a set beats a clear in the same cycle
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      tmr_flag <= 1'b0;
      alm_flag <= 1'b0;
      lost_flag <= 1'b1;
    end else begin
      if (tmr_event) begin
        tmr_flag <= 1'b1;
      end else if (wsel[`RTC_A_FLAG] && !req.wdata[`RTC_B_TMR]) begin
        tmr_flag <= 1'b0;
      end
      if (alarm_event) begin
        alm_flag <= 1'b1;
      end else if (wsel[`RTC_A_FLAG] && !req.wdata[`RTC_B_ALM]) begin
        alm_flag <= 1'b0;
      end
      if (wsel[`RTC_A_FLAG] && !req.wdata[`RTC_B_LOST]) begin
        lost_flag <= 1'b0;
      end
    end
  end

  // Timer interrupt auto-release window
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rtn <= 20'h0_0000;
    end else if (tmr_event && tmr_irq_en) begin
      rtn <= (ext[1:0] == RTC_SRC_4096) ? 20'(TRTN_FAST) : 20'(TRTN_SLOW);
    end else if (!tmr_flag || !tmr_irq_en || !timer_run) begin
      rtn <= 20'h0_0000;
    end else if (rtn != 20'h0_0000) begin
      rtn <= rtn - 20'h0_0001;
    end
  end

  assign irq_req = (alm_flag && alm_irq_en) || (rtn != 20'h0_0000);

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      IRQ_N_OUT <= 1'b1;
      IRQ_N_OE <= 1'b0;
    end else begin
      IRQ_N_OUT <= !irq_req;
      IRQ_N_OE <= irq_req;
    end
  end

  // Enable pin filter and clock output
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      oe_sync <= 3'b000;
      oe_filt <= 1'b0;
    end else begin
      oe_sync <= {oe_sync[1:0], CLOCK_OUT_ENABLE_PIN};
      if (oe_sync[1] == oe_sync[2]) oe_filt <= oe_sync[2];
    end
  end

  always_comb begin
    case (ext[3:2])
      2'b01:   sel_bit = pre[5];
      2'b10:   sel_bit = pre[15];
      default: sel_bit = pre[0];
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      CLOCK_OUT_PIN <= 1'b0;
      CLOCK_OUT_OE <= 1'b0;
    end else begin
      CLOCK_OUT_PIN <= oe_filt && sel_bit;
      CLOCK_OUT_OE <= oe_filt;
    end
  end

  // Register read-back
  always_comb begin
    case (req.addr)
      `RTC_A_SEC:   rd_mux = sec;
      `RTC_A_MIN:   rd_mux = mins;
      `RTC_A_HOUR:  rd_mux = hour;
      `RTC_A_WEEK:  rd_mux = {1'b0, wday};
      `RTC_A_DATE:  rd_mux = date;
      `RTC_A_MONTH: rd_mux = month;
      `RTC_A_YEAR:  rd_mux = year;
      `RTC_A_AMIN:  rd_mux = al_min;
      `RTC_A_AHOUR: rd_mux = al_hour;
      `RTC_A_ADAY:  rd_mux = al_day;
      `RTC_A_TLO:   rd_mux = tp_lo;
      `RTC_A_THI:   rd_mux = tp_hi;
      `RTC_A_EXT:   rd_mux = ext;
      `RTC_A_FLAG:  rd_mux = {3'h0, tmr_flag, alm_flag, 1'b0, lost_flag, 1'b0};
      `RTC_A_CTRL:  rd_mux = {3'h0, tmr_irq_en, alm_irq_en, 1'b0, stop, 1'b0};
      default:      rd_mux = ram;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= 8'h00;
    end else if (req.rd) begin
      REG_RDATA <= rd_mux;
    end
  end

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  a_sec_rollover: assert property (sec_wrap && !wsel[`RTC_A_MIN] |=> sec == 8'h00 && !$stable(mins))
    else $error("seconds did not roll over");
  a_sec_prescale: assert property (wsel[`RTC_A_SEC] |=> !sec_tick [*8])
    else $error("second tick too soon after seconds write");
  a_hour_wrap: assert property (hour_wrap && !wsel[`RTC_A_HOUR] |=> hour == 8'h00)
    else $error("hour did not wrap at 23");
  a_week_rotate: assert property (hour_wrap && !wsel[`RTC_A_WEEK] |=>
    wday == {$past(wday[5:0]), $past(wday[6])})
    else $error("weekday did not rotate");
  a_feb_length: assert property (hour_wrap && month == 8'h02 && date == 8'h28 && !wsel[`RTC_A_DATE] &&
    !wsel[`RTC_A_YEAR] |=> date == ((((year[3:0] + {2'b00, year[4], 1'b0}) & 4'h3) == 4'h0) ? 8'h29 : 8'h01))
    else $error("february length wrong");
  a_timer_reload: assert property (tmr_event |=> tcount == $past(preset) && tmr_flag)
    else $error("timer did not reload and flag");
  a_alarm_flag: assert property (alarm_event |=> alm_flag ##1 (IRQ_N_OE || !alm_irq_en))
    else $error("alarm flag or pin missing");
  a_lost_sticky: assert property (lost_flag && !wsel[`RTC_A_FLAG] |=> lost_flag)
    else $error("data-lost flag dropped");
  a_irq_release: assert property ($fell(tmr_irq_en) && !alm_irq_en |-> ##2 !IRQ_N_OE)
    else $error("interrupt not released");
  a_ro_bits: assert property (req.rd && req.addr == `RTC_A_HOUR |=> REG_RDATA[7:6] == 2'b00)
    else $error("prohibited bits read nonzero");

endmodule

// ==== tb/rtc_host.sv ====
`timescale 1ns/100ps
module rtc_host
  import rtc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] rdata,
  input  wire logic       irq_n_out,
  input  wire logic       irq_n_oe,
  output rtc_req_t        req,
  output logic            irq_line
);
  int unsigned slow = 0;

  // Board pull-up on the open-drain line
  assign irq_line = irq_n_oe ? irq_n_out : 1'b1;

  initial begin
    req = '0;
  end

  function automatic logic [7:0] keep_mask(input logic [3:0] addr);
    case (addr)
      4'hD, 4'hF: return 8'h7F;
      4'hE: return 8'h7E;
      default: return 8'hFF;
    endcase
  endfunction

  // Extra idle cycles let the host act slowly
  task automatic reg_write(input logic [3:0] addr, input logic [7:0] data);
    repeat (slow) @(negedge clk_sys);
    @(negedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data & keep_mask(addr)};
    @(negedge clk_sys);
    req <= '0;
  endtask

  task automatic reg_read(input logic [3:0] addr, output logic [7:0] data);
    repeat (slow) @(negedge clk_sys);
    @(negedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(negedge clk_sys);
    req <= '0;
    data = rdata & keep_mask(addr);
  endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import rtc_pkg::*;
  localparam int unsigned CLK_HZ = 65536;
  localparam int unsigned TRTN_FAST = 4;
  localparam logic [3:0] TA [13] = '{4'h7, 4'h7, 4'h7, 4'h7, 4'h0, 4'h2, 4'h5, 4'h3, 4'h4, 4'hD, 4'hF, 4'hC, 4'hB};
  localparam logic [7:0] TW [13] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'hD9, 8'hE3, 8'hF2, 8'hC0, 8'hE1, 8'h20, 8'h67,
                                     8'hF7, 8'h3C};
  localparam logic [7:0] TR [13] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h59, 8'h23, 8'h12, 8'h40, 8'h21, 8'h00, 8'h02,
                                     8'hF7, 8'h3C};
  localparam logic [3:0] CA [13] = '{4'hE, 4'hF, 4'hD, 4'h8, 4'h9, 4'hA, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h0};
  localparam logic [7:0] CW [13] = '{8'h00, 8'h08, 8'h40, 8'h00, 8'h80, 8'h01, 8'h59, 8'h23, 8'h40, 8'h28, 8'h02,
                                     8'h01, 8'h59};
  localparam logic [3:0] RA [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hE};
  localparam logic [7:0] RE [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h01, 8'h08};

  logic       clk_sys;
  logic       nrst;
  logic       out_en;
  rtc_req_t   req;
  logic [7:0] rdata;
  logic       clk_pin;
  logic       clk_oe;
  logic       irq_out;
  logic       irq_oe;
  logic       irq_line;
  logic [7:0] d;
  int         mismatches = 0;
  int         check_count = 0;
  int         n;
  int         w;

  rtc_core #(.CLK_HZ(CLK_HZ), .TRTN_FAST(TRTN_FAST), .TRTN_SLOW(20)) i_rtc_core (
    .CLK_SYS              (clk_sys),
    .NRST                 (nrst),
    .REG_WR               (req.wr),
    .REG_RD               (req.rd),
    .REG_ADDR             (req.addr),
    .REG_WDATA            (req.wdata),
    .REG_RDATA            (rdata),
    .CLOCK_OUT_ENABLE_PIN (out_en),
    .CLOCK_OUT_PIN        (clk_pin),
    .CLOCK_OUT_OE         (clk_oe),
    .IRQ_N_OUT            (irq_out),
    .IRQ_N_OE             (irq_oe)
  );

  rtc_host i_rtc_host (
    .clk_sys   (clk_sys),
    .rdata     (rdata),
    .irq_n_out (irq_out),
    .irq_n_oe  (irq_oe),
    .req       (req),
    .irq_line  (irq_line)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    i_rtc_host.reg_write(a, v);
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
    i_rtc_host.reg_read(a, d);
    check(what, 16'(d), 16'(exp));
  endtask

  // Counts falling edges until a rise of the selected output, lim + 1 if none
  task automatic wait_rise(input bit sel, input int lim, input bit must, output int cnt);
    logic prv;
    logic cur;
    prv = sel ? clk_pin : irq_oe;
    for (cnt = 1; cnt <= lim; cnt++) begin
      @(negedge clk_sys);
      cur = sel ? clk_pin : irq_oe;
      if (cur === 1'b1 && prv === 1'b0)
        break;
      prv = cur;
    end
    if (must && cnt > lim) begin
      mismatches++;
      $display("MISMATCH output rise expected 1 seen 0");
      test_done();
    end
  endtask

  initial begin
    nrst = 1'b0;
    out_en = 1'b0;
    repeat (2) @(negedge clk_sys);
    nrst = 1'b1;
    rd_chk("flags at reset", 4'hE, 8'h02);
    check("irq enable at reset", 16'(irq_oe), 16'h0001 - 16'h0001);
    wr(4'hE, 8'h1A);
    rd_chk("flags after writing ones", 4'hE, 8'h02);
    wr(4'hE, 8'h00);
    rd_chk("flags after clear", 4'hE, 8'h00);
    for (int i = 0; i < 13; i++) begin
      i_rtc_host.slow = i % 2;
      wr(TA[i], TW[i]);
      rd_chk("register readback", TA[i], TR[i]);
    end
    i_rtc_host.slow = 0;
    wr(4'hB, 8'h02);
    wr(4'hC, 8'h00);
    wr(4'hF, 8'h10);
    wr(4'hD, 8'h10);
    wait_rise(1'b0, 300, 1'b1, n);
    for (w = 0; w < 50 && irq_oe === 1'b1; w++)
      @(negedge clk_sys);
    check("irq low width", 16'(w >= TRTN_FAST && w <= TRTN_FAST + 1), 16'h0001);
    wait_rise(1'b0, 300, 1'b1, n);
    check("timer event period", 16'(w + n), 16'h0020);
    rd_chk("timer flag", 4'hE, 8'h10);
    wr(4'hD, 8'h00);
    wr(4'hB, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(4'hD, 8'h00);
      wr(4'hD, 8'h10 | 8'(i));
      wait_rise(1'b0, 4200, i < 2, n);
      if (i < 2)
        wait_rise(1'b0, 4200, 1'b1, n);
      check("timer source period", 16'(n), i == 0 ? 16'h0010 : (i == 1 ? 16'h0400 : 16'h1069));
    end
    wr(4'hD, 8'h00);
    wr(4'hF, 8'h00);
    wr(4'hE, 8'h00);
    wr(4'hD, 8'h10);
    wait_rise(1'b0, 200, 1'b0, n);
    check("irq without enable", 16'(n), 16'h00C9);
    rd_chk("flag without enable", 4'hE, 8'h10);
    wr(4'hD, 8'h00);
    wr(4'hE, 8'h00);
    repeat (100) @(negedge clk_sys);
    rd_chk("flag after stop", 4'hE, 8'h00);
    out_en = 1'b1;
    for (n = 0; n < 10 && clk_oe !== 1'b1; n++)
      @(negedge clk_sys);
    check("clock out enabled", 16'(clk_oe), 16'h0001);
    for (int i = 0; i < 4; i++) begin
      wr(4'hD, 8'(i << 2));
      wait_rise(1'b1, i == 2 ? 20 : 300, i != 2, n);
      wait_rise(1'b1, 300, i != 2, n);
      check("clock out period", 16'(n), i == 2 ? 16'h012D : (i == 1 ? 16'h0040 : 16'h0002));
    end
    out_en = 1'b0;
    for (n = 0; n < 10 && clk_oe !== 1'b0; n++)
      @(negedge clk_sys);
    check("clock out released", 16'(clk_oe), 16'h0000);
    for (int i = 0; i < 13; i++)
      wr(CA[i], CW[i]);
    repeat (64000) @(negedge clk_sys);
    rd_chk("seconds before tick", 4'h0, 8'h59);
    wait_rise(1'b0, 2000, 1'b1, n);
    check("alarm irq line", 16'(irq_line), 16'h0000);
    for (int i = 0; i < 8; i++)
      rd_chk("calendar rollover", RA[i], RE[i]);
    test_done();
  end
endmodule
